// File: ictree_top.sv
// Purpose: Pad ring wrapper that applies in-circuit test mode to the device pins.
// Assumes: Core logic supplies the wanted pin drive; tester drives pins asynchronously.
// Notes:   Test mode and the tree act without the clock, so a tester needs no clock.
`timescale 1ns/100ps

module ictree_top
	import ictree_pkg::*;
#(
	parameter int OTHER_PAIRS = `ICTREE_OTHER_PAIRS
) (
	// Clock and reset.
	input  wire logic                          clk,
	input  wire logic                          srst,
	// Test mode select pin, active low.
	input  wire logic                          test_mode_sel_n,
	// Reset pin as seen by the tree.
	input  wire logic                          reset_pin,
	// Address input pins A1..A7.
	input  wire logic [`ICTREE_ADDR_MSB:`ICTREE_ADDR_LSB] addr_pin,
	// Bidirectional data pins.
	input  wire logic [`ICTREE_DATA_W-1:0]     data_in,
	output logic      [`ICTREE_DATA_W-1:0]     data_out,
	output logic      [`ICTREE_DATA_W-1:0]     data_oe,
	// Bidirectional shared bus timing pin.
	input  wire logic                          shared_bus_timing_pin_in,
	output logic                               shared_bus_timing_pin_out,
	output logic                               shared_bus_timing_pin_oe,
	// Further paired pins, member A at bit k, member B at bit k.
	input  wire logic [OTHER_PAIRS-1:0]        other_pin_a,
	input  wire logic [OTHER_PAIRS-1:0]        other_pin_b,
	// Pins outside the tree.
	input  wire logic                          primary_timing_input,
	output logic                               counter0_output_pin,
	output logic                               counter0_output_pin_oe,
	// Generic tri-state outputs.
	output logic [`ICTREE_GEN_OUT_W-1:0]       gen_out,
	output logic [`ICTREE_GEN_OUT_W-1:0]       gen_oe,
	// Core drive request.
	input  wire ictree_drive_t                 core_drive,
	// Tree output pin and synchronised test status.
	output logic                               tree_out,
	output logic                               test_mode_seen
);

	localparam int NUM_ADDR_PAIRS = (ADDR_N + 1) / 2;
	localparam int NUM_DATA_PAIRS = `ICTREE_DATA_W / 2;
	localparam int NUM_PAIRS      = NUM_ADDR_PAIRS + NUM_DATA_PAIRS + OTHER_PAIRS;

	////////////////////////////////////////////////////////////////////////////////
	// Registered drive state.

	ictree_state_t state_ff;
	ictree_state_t nxt_state;
	logic          test_active;

	// The pin table marks the select low-active; a floating pin pulls up to normal mode.
	assign test_active = ~test_mode_sel_n;

	always_comb begin
		nxt_state          = state_ff;
		nxt_state.drv      = core_drive;
		nxt_state.sel_sync = {state_ff.sel_sync[`ICTREE_SYNC_DEPTH-2:0], ~test_mode_sel_n};
		// A change counts only once the last two stages agree, which filters a slow edge.
		if (state_ff.sel_sync[`ICTREE_SYNC_DEPTH-1] == state_ff.sel_sync[`ICTREE_SYNC_DEPTH-2]) begin
			nxt_state.test_seen = state_ff.sel_sync[`ICTREE_SYNC_DEPTH-1];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff.drv.gen_val    <= '0;
			state_ff.drv.gen_en     <= '0;
			state_ff.drv.data_val   <= '0;
			state_ff.drv.data_en    <= `ICTREE_RST_EN;
			state_ff.drv.timing_val <= `ICTREE_RST_VAL;
			state_ff.drv.timing_en  <= `ICTREE_RST_EN;
			state_ff.drv.cnt0_val   <= `ICTREE_RST_VAL;
			state_ff.drv.cnt0_en    <= `ICTREE_RST_EN;
			state_ff.sel_sync       <= '0;
			state_ff.test_seen      <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output drivers; test mode overrides enables without waiting for a clock edge.

	assign gen_out                   = state_ff.drv.gen_val;
	assign gen_oe                    = state_ff.drv.gen_en & {`ICTREE_GEN_OUT_W{~test_active}};
	assign data_out                  = state_ff.drv.data_val;
	assign data_oe                   = {`ICTREE_DATA_W{state_ff.drv.data_en & ~test_active}};
	assign shared_bus_timing_pin_out = state_ff.drv.timing_val;
	assign shared_bus_timing_pin_oe  = state_ff.drv.timing_en & ~test_active;
	assign counter0_output_pin       = state_ff.drv.cnt0_val;
	assign counter0_output_pin_oe    = state_ff.drv.cnt0_en & ~test_active;
	assign test_mode_seen            = state_ff.test_seen;

	////////////////////////////////////////////////////////////////////////////////
	// Pair assembly: address, then data, then the further pins.

	logic [NUM_PAIRS-1:0] pair_a;
	logic [NUM_PAIRS-1:0] pair_b;
	logic [ADDR_N:0]      addr_ext;

	// The odd last address line borrows the shared timing pin as its partner.
	assign addr_ext = {shared_bus_timing_pin_in, addr_pin};

	genvar g;
	generate
		for (g = 0; g < NUM_ADDR_PAIRS; g++) begin : g_addr
			assign pair_a[g] = addr_ext[2*g];
			assign pair_b[g] = addr_ext[2*g+1];
		end
		for (g = 0; g < NUM_DATA_PAIRS; g++) begin : g_data
			assign pair_a[NUM_ADDR_PAIRS+g] = data_in[2*g];
			assign pair_b[NUM_ADDR_PAIRS+g] = data_in[2*g+1];
		end
	endgenerate

	// Counter-0 output, primary timing input and the select pin never reach the tree.
	assign pair_a[NUM_PAIRS-1:NUM_ADDR_PAIRS+NUM_DATA_PAIRS] = other_pin_a;
	assign pair_b[NUM_PAIRS-1:NUM_ADDR_PAIRS+NUM_DATA_PAIRS] = other_pin_b;

	////////////////////////////////////////////////////////////////////////////////
	// Gate tree; its pin is the one output that keeps driving in test mode.

	ictree_gate_tree #(
		.NUM_PAIRS (NUM_PAIRS)
	) u_tree (
		.pair_a    (pair_a),
		.pair_b    (pair_b),
		.reset_pin (reset_pin),
		.tree_out  (tree_out)
	);

endmodule // ictree_top

// File: ictree_cfg.svh
// Purpose: Constants for the in-circuit pin connectivity tree.
// Assumes: Included by its bare name from the package file only; the design modules use its macros without including it.
// Notes:   Definitions only; pair counts follow the fixed pin grouping.
`ifndef ICTREE_CFG_SVH
`define ICTREE_CFG_SVH

// Address lines A1..A7 on the package.
`define ICTREE_ADDR_LSB        1
`define ICTREE_ADDR_MSB        7
// Data lines D0..D15 on the package.
`define ICTREE_DATA_W          16
// Further documented pin pairs beyond address and data lines.
`define ICTREE_OTHER_PAIRS     40
// Width of the generic tri-state output group that the core drives.
`define ICTREE_GEN_OUT_W       32
// Reset values of the registered output state.
`define ICTREE_RST_VAL         1'b0
`define ICTREE_RST_EN          1'b0
// Synchroniser depth for the test select pin.
`define ICTREE_SYNC_DEPTH      3

`endif

// File: ictree_pkg.sv
// Purpose: Types shared by the connectivity tree design.
// Assumes: ictree_cfg.svh holds every constant.
// Notes:   Pin groups travel as packed structs.
`include "ictree_cfg.svh"

package ictree_pkg;

	localparam int ADDR_N = `ICTREE_ADDR_MSB - `ICTREE_ADDR_LSB + 1;

	// Every tri-state pin group (generic, data, timing, counter-0) as the core wants it driven.
	typedef struct packed {
		logic [`ICTREE_GEN_OUT_W-1:0] gen_val;
		logic [`ICTREE_GEN_OUT_W-1:0] gen_en;
		logic [`ICTREE_DATA_W-1:0]    data_val;
		logic                         data_en;
		logic                         timing_val;
		logic                         timing_en;
		logic                         cnt0_val;
		logic                         cnt0_en;
	} ictree_drive_t;

	// Registered state of the top module.
	typedef struct packed {
		ictree_drive_t                  drv;
		logic [`ICTREE_SYNC_DEPTH-1:0] sel_sync;
		logic                           test_seen;
	} ictree_state_t;

endpackage

// File: ictree_gate_tree.sv
// Purpose: Combinational AND/OR connectivity tree for in-circuit test.
// Assumes: Pair members arrive as two equal vectors, member A and member B.
// Notes:   No clock; the tester watches the result directly on the pin.
`timescale 1ns/100ps

module ictree_gate_tree #(
	parameter int NUM_PAIRS = 4
) (
	// Pair members.
	input  wire logic [NUM_PAIRS-1:0] pair_a,
	input  wire logic [NUM_PAIRS-1:0] pair_b,
	// Reset pin, entering the OR directly.
	input  wire logic                 reset_pin,
	// Tree result.
	output logic                      tree_out
);

	logic [NUM_PAIRS-1:0] pair_and;

	genvar g;
	generate
		for (g = 0; g < NUM_PAIRS; g++) begin : g_pair
			assign pair_and[g] = pair_a[g] & pair_b[g];
		end
	endgenerate

	// Inverted so that an idle board reads high and any hit pulls it low.
	assign tree_out = ~(|pair_and | reset_pin);

endmodule // ictree_gate_tree

// File: ictree_sva.sv
// Purpose: Checker for the connectivity tree and test mode pins.
// Assumes: Pins change only just after clk rises.
// Notes:   The tree needs no clock; it is sampled on clk only to watch it.
`timescale 1ns/100ps
module ictree_sva #(parameter int OTHER_PAIRS = 4) (
	input wire logic clk, srst, test_mode_sel_n, reset_pin, primary_timing_input,
	input wire logic shared_bus_timing_pin_in, shared_bus_timing_pin_oe,
	input wire logic counter0_output_pin_oe, tree_out, test_mode_seen,
	input wire logic [7:1] addr_pin,
	input wire logic [15:0] data_in, data_oe,
	input wire logic [OTHER_PAIRS-1:0] other_pin_a, other_pin_b,
	input wire logic [31:0] gen_oe
);
	logic any_p;
	assign any_p = (addr_pin[1] & addr_pin[2]) | (addr_pin[3] & addr_pin[4])
		| (addr_pin[5] & addr_pin[6]) | (addr_pin[7] & shared_bus_timing_pin_in)
		| (|(data_in & (data_in >> 1) & 16'h5555)) | (|(other_pin_a & other_pin_b));
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_sel_held; !test_mode_sel_n [*6]; endsequence
	sequence s_sel_off; test_mode_sel_n [*6]; endsequence
	a_tree_equation: assert property (tree_out == !(any_p | reset_pin))
		else $error("tree output wrong");
	a_test_oe_off: assert property (!test_mode_sel_n |-> data_oe == 0 && gen_oe == 0
		&& !counter0_output_pin_oe && !shared_bus_timing_pin_oe) else $error("output not floated");
	a_low_gives_high: assert property (!test_mode_sel_n && !reset_pin && !any_p |-> tree_out)
		else $error("tree low with pins low");
	a_pair_pulls_low: assert property (any_p |-> !tree_out)
		else $error("pair did not pull tree low");
	a_reset_direct: assert property ($changed(reset_pin) && !any_p && $past(!any_p) |-> $changed(tree_out))
		else $error("reset toggle not seen");
	a_timing_pair: assert property (addr_pin[7] && shared_bus_timing_pin_in |-> !tree_out)
		else $error("last address pair wrong");
	a_excluded_pin: assert property ($changed(primary_timing_input) && !any_p && !reset_pin
		|-> tree_out) else $error("excluded pin moved tree");
	a_seen_set: assert property (s_sel_held |-> test_mode_seen)
		else $error("test mode not seen");
	a_seen_clear: assert property (s_sel_off |-> !test_mode_seen)
		else $error("test mode seen wrongly");
endmodule // ictree_sva
bind ictree_top ictree_sva #(.OTHER_PAIRS(OTHER_PAIRS)) u_sva (.*);

// File: ictree_tester.sv
// Purpose: Board tester model that drives the tree pins.
// Assumes: Pair k is member A in pa[k] and member B in pb[k].
// Notes:   Moves land after a rising edge and settle by the falling edge.
`timescale 1ns/100ps
module ictree_tester #(parameter int OTHER_PAIRS = 4, parameter int NP = 12 + OTHER_PAIRS) (
	input wire logic clk,
	output logic test_mode_sel_n, reset_pin, primary_timing_input, shared_bus_timing_pin_in,
	output logic [7:1] addr_pin,
	output logic [15:0] data_in,
	output logic [OTHER_PAIRS-1:0] other_pin_a, other_pin_b
);
	logic [NP-1:0] pa = '0, pb = '0;
	initial {test_mode_sel_n, reset_pin, primary_timing_input} = 3'b100;
	always_comb begin
		addr_pin = {pa[3], pb[2], pa[2], pb[1], pa[1], pb[0], pa[0]};
		shared_bus_timing_pin_in = pb[3];
		for (int j = 0; j < 8; j++) begin
			data_in[2*j] = pa[4+j];
			data_in[2*j+1] = pb[4+j];
		end
		other_pin_a = pa[NP-1:12];
		other_pin_b = pb[NP-1:12];
	end
	task automatic put(input int k, input logic a, input logic b);
		@(posedge clk);
		pa[k] <= a;
		pb[k] <= b;
		@(negedge clk);
	endtask
	task automatic ctl(input logic sel_n, input logic rst, input logic pt);
		@(posedge clk);
		test_mode_sel_n <= sel_n;
		reset_pin <= rst;
		primary_timing_input <= pt;
		@(negedge clk);
	endtask
endmodule // ictree_tester

// File: ictree_top_tb.sv
// Purpose: Self-checking bench for the connectivity tree top.
// Assumes: The tester model owns every tree pin.
// Notes:   Outputs are judged at the falling edge, once settled.
`timescale 1ns/100ps
module ictree_top_tb import ictree_pkg::*;;
	localparam int OP = 4;
	logic clk = 1'b0, srst = 1'b1, sel_n, rst_pin, pti, tim_in, tree_out, c0_oe, t_oe, seen;
	logic [7:1] addr_pin;
	logic [15:0] data_in, data_oe, d_out;
	logic [OP-1:0] oa, ob;
	logic [31:0] gen_oe, g_out;
	ictree_drive_t core_drive = '0;
	int errors = 0, n_compared = 0;
	initial forever #10 clk = ~clk;
	ictree_tester #(.OTHER_PAIRS(OP)) tst (.clk(clk), .test_mode_sel_n(sel_n),
		.reset_pin(rst_pin), .primary_timing_input(pti), .shared_bus_timing_pin_in(tim_in),
		.addr_pin(addr_pin), .data_in(data_in), .other_pin_a(oa), .other_pin_b(ob));
	ictree_top #(.OTHER_PAIRS(OP)) uut (.clk(clk), .srst(srst), .test_mode_sel_n(sel_n),
		.reset_pin(rst_pin), .addr_pin(addr_pin), .data_in(data_in), .data_out(d_out),
		.data_oe(data_oe), .shared_bus_timing_pin_in(tim_in), .shared_bus_timing_pin_out(),
		.shared_bus_timing_pin_oe(t_oe), .other_pin_a(oa), .other_pin_b(ob),
		.primary_timing_input(pti), .counter0_output_pin(), .counter0_output_pin_oe(c0_oe),
		.gen_out(g_out), .gen_oe(gen_oe), .core_drive(core_drive), .tree_out(tree_out),
		.test_mode_seen(seen));
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic t_mode;
		@(posedge clk);
		core_drive <= '1;
		repeat (2) @(negedge clk);
		chk("oe normal", {gen_oe[31:18], data_oe, c0_oe, t_oe}, 32'hffffffff);
		chk("oe normal low", gen_oe[17:0], 32'h3ffff);
		chk("gen out", g_out, 32'hffffffff);
		chk("data out", d_out, 32'hffff);
		chk("seen idle", seen, 1'b0);
		tst.ctl(1'b0, 1'b0, 1'b0);
		chk("oe test", gen_oe | data_oe | c0_oe | t_oe, 32'h0);
		chk("all low", tree_out, 1'b1);
		repeat (6) @(negedge clk);
		chk("seen set", seen, 1'b1);
	endtask
	task automatic t_pairs;
		for (int k = 0; k < 12 + OP; k++) begin
			tst.put(k, 1'b1, 1'b1);
			chk("both high", tree_out, 1'b0);
			tst.put(k, 1'b0, 1'b1);
			chk("a low", tree_out, 1'b1);
			tst.put(k, 1'b1, 1'b1);
			chk("a high", tree_out, 1'b0);
			tst.put(k, 1'b1, 1'b0);
			chk("b low", tree_out, 1'b1);
			tst.put(k, 1'b1, 1'b1);
			chk("b high", tree_out, 1'b0);
			tst.put(k, 1'b0, 1'b0);
			chk("both low", tree_out, 1'b1);
			if (k > 0) begin
				tst.put(k - 1, 1'b1, 1'b0);
				tst.put(k, 1'b0, 1'b1);
				chk("cross pair", tree_out, 1'b1);
				tst.put(k - 1, 1'b0, 1'b0);
				tst.put(k, 1'b0, 1'b0);
			end
		end
	endtask
	task automatic t_reset;
		tst.ctl(1'b0, 1'b1, 1'b0);
		chk("reset high", tree_out, 1'b0);
		tst.ctl(1'b0, 1'b0, 1'b1);
		chk("reset low", tree_out, 1'b1);
		tst.ctl(1'b1, 1'b0, 1'b0);
		chk("oe back", gen_oe, 32'hffffffff);
		repeat (6) @(negedge clk);
		chk("seen clear", seen, 1'b0);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_mode;
		t_pairs;
		t_reset;
		print_verdict;
	end
	initial begin
		#100000;
		errors++;
		print_verdict;
	end
endmodule // ictree_top_tb
